// ===== ebg_grant_ctrl.sv
// External bus takeover arbiter with memory interface drivers.
`timescale 1ns/1ps
`include "ebg_regs.svh"
module ebg_grant_ctrl
  import ebg_pkg::*;
#(
  parameter bit LEGACY_SAME_CYCLE = 1'b0
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic core_rst_n,
  input wire logic ext_takeover_req_n,
  input wire logic run_on_mode,
  input wire logic boot_active,
  input wire logic boot_byte_done,
  input wire logic acc_req,
  input wire ebg_access_s acc,
  input wire logic [`EBG_WAIT_W-1:0] pm_waits,
  input wire logic pm_waits_load,
  input wire logic [`EBG_DATA_W-1:0] data_in,
  output logic acc_done,
  output logic [`EBG_DATA_W-1:0] rdata,
  output logic core_halt,
  output logic takeover_grant_n,
  output logic [`EBG_ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [`EBG_DATA_W-1:0] data_out,
  output logic data_oe,
  output ebg_strobe_s strobe_out,
  output logic strobe_oe
);
  ebg_state_e state_reg;
  ebg_state_e state_next;
  logic req_sync_n;
  logic req_act;
  logic [`EBG_WAIT_W-1:0] pm_waits_reg;
  logic acc_last;
  logic drain_done;
  logic acc_start;
  logic boot_hold_reg;
  logic granted;
  logic [`EBG_ADDR_W-1:0] addr_reg;
  logic [`EBG_DATA_W-1:0] wdata_reg;
  logic write_reg;
  ebg_strobe_s strobe_reg;
  logic in_acc_reg;

  // The request is never trusted until it has crossed two flops.
  ebg_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_n(ext_takeover_req_n),
    .sync_n(req_sync_n)
  );

  assign req_act = !req_sync_n;

  // Wait count for program memory; core reset restores the slowest value.
  always_ff @(posedge mclk) begin
    if (!rst_n || !core_rst_n) begin
      pm_waits_reg <= `EBG_PM_WAIT_RESET;
    end else if (pm_waits_load) begin
      pm_waits_reg <= pm_waits;
    end
  end

  // No new access may begin once the bus is handed over or a takeover
  // is pending, so the grant can slip between two accesses.
  assign acc_start = acc_req && (state_reg == EBG_ST_OWN) && !req_act
    && !in_acc_reg;

  // The counter starts on the first cycle the pins carry the access, so
  // an access with N wait states keeps its strobes for N + 1 cycles.
  ebg_wait u_wait (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(in_acc_reg),
    .waits(pm_waits_reg),
    .busy(),
    .last(acc_last)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_acc_reg <= 1'b0;
    end else if (acc_last) begin
      in_acc_reg <= 1'b0;
    end else if (acc_start) begin
      in_acc_reg <= 1'b1;
    end
  end

  // Latch the access so the pins hold steady for all its wait states.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      write_reg <= 1'b0;
      strobe_reg <= '1;
    end else if (acc_start) begin
      addr_reg <= acc.addr;
      wdata_reg <= acc.wdata;
      write_reg <= acc.write;
      strobe_reg <= acc.strobe;
    end else if (acc_last || !in_acc_reg) begin
      strobe_reg <= '1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (in_acc_reg && acc_last && !write_reg) begin
      rdata <= data_in;
    end
  end

  assign acc_done = in_acc_reg && acc_last;

  // The last cycle of an access or of a boot byte already counts as
  // drained, so the registered grant lands in the very next cycle.
  assign drain_done = (!in_acc_reg || acc_done)
    && (!boot_hold_reg || boot_byte_done);

  // A boot byte in flight holds the grant back until it is fully read.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      boot_hold_reg <= 1'b0;
    end else if (boot_byte_done || !boot_active) begin
      boot_hold_reg <= 1'b0;
    end else if (boot_active) begin
      boot_hold_reg <= 1'b1;
    end
  end

  // Core reset is deliberately not part of this condition: takeover
  // must work while the core is held in reset.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EBG_ST_OWN: begin
        if (req_act) begin
          if (drain_done) begin
            state_next = EBG_ST_GRANTED;
          end else begin
            state_next = EBG_ST_DRAIN;
          end
        end
      end
      EBG_ST_DRAIN: begin
        if (!req_act) begin
          state_next = EBG_ST_OWN;
        end else if (drain_done) begin
          state_next = EBG_ST_GRANTED;
        end
      end
      EBG_ST_GRANTED: begin
        if (!req_act) begin
          state_next = EBG_ST_OWN;
        end
      end
      default: begin
        state_next = EBG_ST_OWN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= EBG_ST_OWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // The legacy variant shows the grant combinationally from the state
  // decision, trading a cycle of latency for a longer output path.
  assign granted = LEGACY_SAME_CYCLE ? (state_next == EBG_ST_GRANTED)
    : (state_reg == EBG_ST_GRANTED);

  always_comb begin
    takeover_grant_n = !granted;
    addr_oe = !granted;
    strobe_oe = !granted;
    data_oe = !granted && in_acc_reg && write_reg;
    addr_out = addr_reg;
    data_out = wdata_reg;
    strobe_out = in_acc_reg ? strobe_reg : '1;
  end

  // Halt at the grant unless run-on is set; then stall only when the core
  // wants the external bus. Release restores execution in place.
  always_comb begin
    if (!granted && state_reg != EBG_ST_DRAIN) begin
      core_halt = 1'b0;
    end else if (run_on_mode) begin
      core_halt = acc_req;
    end else begin
      core_halt = granted || (acc_req && !in_acc_reg);
    end
  end
endmodule

// ===== ebg_regs.svh
// Constants for the external bus grant control block.
`ifndef EBG_REGS_SVH
`define EBG_REGS_SVH
`define EBG_ADDR_W 14
`define EBG_DATA_W 24
`define EBG_WAIT_W 3
`define EBG_PM_WAIT_RESET 3'h7
`define EBG_SYNC_STAGES 2
`endif

// ===== ebg_pkg.sv
// Types shared by the external bus grant control block.
`include "ebg_regs.svh"
package ebg_pkg;
  typedef enum logic [1:0] {
    EBG_ST_OWN = 2'b00,
    EBG_ST_DRAIN = 2'b01,
    EBG_ST_GRANTED = 2'b10
  } ebg_state_e;

  // Strobes of the external memory interface, all active low.
  typedef struct packed {
    logic prog_mem_select_n;
    logic data_mem_select_n;
    logic boot_mem_select_n;
    logic rd_n;
    logic wr_n;
  } ebg_strobe_s;

  // One external access as issued by the core.
  typedef struct packed {
    logic [`EBG_ADDR_W-1:0] addr;
    logic [`EBG_DATA_W-1:0] wdata;
    logic write;
    ebg_strobe_s strobe;
  } ebg_access_s;
endpackage

// ===== ebg_sync.sv
// Two-stage synchroniser for an asynchronous active-low level.
`timescale 1ns/1ps
module ebg_sync
  import ebg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_n,
  output logic sync_n
);
  logic meta_reg;

  // The first stage feeds only the second; resets to inactive high.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_n <= 1'b1;
    end else begin
      meta_reg <= async_n;
      sync_n <= meta_reg;
    end
  end
endmodule

// ===== ebg_wait.sv
// Wait-state counter that marks the last cycle of an external access.
`timescale 1ns/1ps
`include "ebg_regs.svh"
module ebg_wait
  import ebg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [`EBG_WAIT_W-1:0] waits,
  output logic busy,
  output logic last
);
  logic [`EBG_WAIT_W-1:0] cnt_reg;
  logic active_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (start && !active_reg) begin
      active_reg <= (waits != '0);
      cnt_reg <= waits;
    end else if (active_reg) begin
      cnt_reg <= cnt_reg - 3'h1;
      active_reg <= (cnt_reg != 3'h1);
    end
  end

  assign busy = start || active_reg;
  // An access ends in its start cycle when it has no wait states.
  assign last = active_reg ? (cnt_reg == 3'h1) : (start && waits == '0);
endmodule

// ===== ebg_grant_ctrl_sva.sv
// Checker for the external bus grant control block.
`timescale 1ns/1ps
module ebg_grant_ctrl_sva
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ext_takeover_req_n,
  input wire logic run_on_mode,
  input wire logic boot_active,
  input wire logic acc_req,
  input wire logic acc_done,
  input wire logic core_halt,
  input wire logic takeover_grant_n,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic strobe_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_grant_drops_oe: assert property (
    !takeover_grant_n |-> !addr_oe && !data_oe && !strobe_oe)
    else $error("drivers on in grant");
  a_grant_halts: assert property (
    !takeover_grant_n && !run_on_mode |-> core_halt)
    else $error("no halt in grant");
  a_runon_keeps_going: assert property (
    !takeover_grant_n && run_on_mode && !acc_req |-> !core_halt)
    else $error("run-on halted");
  a_runon_stalls_access: assert property (
    !takeover_grant_n && acc_req |-> core_halt && !acc_done)
    else $error("access in grant");
  // Three edges: two synchroniser stages plus the registered grant.
  a_idle_grant_time: assert property (
    $fell(ext_takeover_req_n) && takeover_grant_n && !boot_active &&
    !acc_req ##1 (!ext_takeover_req_n && !acc_req)[*2]
    |-> takeover_grant_n ##1 !takeover_grant_n)
    else $error("idle grant timing");
  a_done_then_grant: assert property (
    acc_done && !ext_takeover_req_n && !$past(ext_takeover_req_n, 2) &&
    !boot_active |=> !takeover_grant_n)
    else $error("no grant after access");
  a_no_grant_midacc: assert property (
    !takeover_grant_n |-> !acc_done)
    else $error("grant during access");
  a_release_restores: assert property (
    $rose(ext_takeover_req_n) && !takeover_grant_n ##1
    ext_takeover_req_n[*2] |=> takeover_grant_n && addr_oe && strobe_oe)
    else $error("bus not restored");
  c_idle_grant: cover property ($fell(takeover_grant_n) && !acc_req);
  c_runon_stall: cover property (!takeover_grant_n && acc_req);
  c_release: cover property ($rose(takeover_grant_n));
endmodule
bind ebg_grant_ctrl ebg_grant_ctrl_sva u_sva (.*);

// ===== ebg_ext_master.sv
// Behavioural external master that asks for the bus on demand.
`timescale 1ns/1ps
module ebg_ext_master
(
  input wire logic want,
  output logic ext_takeover_req_n
);
  // The pin moves mid-cycle, unrelated to the edge, and idles high.
  assign #3 ext_takeover_req_n = !want;
endmodule

// ===== ebg_grant_ctrl_tb.sv
// Testbench for the external bus grant control block.
`timescale 1ns/1ps
module ebg_grant_ctrl_tb;
  import ebg_pkg::*;
  logic mclk = 0, rst_n = 0, core_rst_n = 1, run_on_mode = 0, want = 0;
  logic boot_active = 0, boot_byte_done = 0, acc_req = 0;
  ebg_access_s acc = '0;
  logic acc_done, core_halt, takeover_grant_n, ext_takeover_req_n;
  logic addr_oe, data_oe, strobe_oe;
  logic [13:0] addr_out;
  logic [23:0] rdata, data_out;
  logic [23:0] data_in = 24'h5a5a5a;
  logic [2:0] pm_waits = 3'h0;
  logic pm_waits_load = 0;
  ebg_strobe_s strobe_out;
  int n_fail = 0, n_tests = 0;
  always #5 mclk = ~mclk;
  ebg_ext_master master (.want(want),
    .ext_takeover_req_n(ext_takeover_req_n));
  ebg_grant_ctrl dut (.mclk(mclk), .rst_n(rst_n), .core_rst_n(core_rst_n),
    .ext_takeover_req_n(ext_takeover_req_n), .run_on_mode(run_on_mode),
    .boot_active(boot_active), .boot_byte_done(boot_byte_done),
    .acc_req(acc_req), .acc(acc), .pm_waits(pm_waits),
    .pm_waits_load(pm_waits_load), .data_in(data_in), .acc_done(acc_done),
    .rdata(rdata), .core_halt(core_halt),
    .takeover_grant_n(takeover_grant_n), .addr_out(addr_out),
    .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe),
    .strobe_out(strobe_out), .strobe_oe(strobe_oe));
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_sig(input bit on_done, input logic v, output int n);
    for (n = 0; n < 40 && (on_done ? acc_done : takeover_grant_n) !== v;
        n++) begin
      cyc();
    end
    if (n == 40) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic t_idle;
    int n;
    want = 1;
    wait_sig(1'b0, 1'b0, n);
    chk(8'(n), 8'h3);
    chk({addr_oe, data_oe, strobe_oe}, 8'h0);
    chk(core_halt, 8'h1);
    want = 0;
    wait_sig(1'b0, 1'b1, n);
    chk(8'(n), 8'h3);
    chk({addr_oe, strobe_oe, core_halt}, 8'h6);
  endtask
  task automatic t_runon;
    int n;
    run_on_mode = 1;
    want = 1;
    wait_sig(1'b0, 1'b0, n);
    chk(core_halt, 8'h0);
    acc_req = 1;
    cyc(2);
    chk({core_halt, acc_done}, 8'h2);
    want = 0;
    wait_sig(1'b1, 1'b1, n);
    acc_req = 0;
    run_on_mode = 0;
    cyc(2);
  endtask
  task automatic t_busy;
    int n;
    acc.addr = 14'h0123;
    acc.strobe = 5'h0d;
    acc_req = 1;
    cyc();
    want = 1;
    wait_sig(1'b1, 1'b1, n);
    chk(8'(n), 8'h7);
    chk(takeover_grant_n, 8'h1);
    chk({addr_oe, strobe_oe, strobe_out}, 8'h6d);
    chk(addr_out, 32'h0123);
    cyc();
    chk({takeover_grant_n, acc_done, core_halt}, 8'h1);
    chk(rdata, 32'h5a5a5a);
    acc.wdata = 24'h00c3a5;
    acc.write = 1'b1;
    acc.strobe = 5'h16;
    want = 0;
    wait_sig(1'b0, 1'b1, n);
    chk(core_halt, 8'h0);
    wait_sig(1'b1, 1'b1, n);
    chk({data_oe, data_out}, 32'h100c3a5);
    acc_req = 0;
    cyc();
  endtask
  task automatic t_nowait;
    int n;
    pm_waits_load = 1;
    cyc();
    pm_waits_load = 0;
    acc_req = 1;
    wait_sig(1'b1, 1'b1, n);
    chk(8'(n), 8'h1);
    acc_req = 0;
    cyc();
  endtask
  task automatic t_boot;
    int n;
    core_rst_n = 0;
    boot_active = 1;
    want = 1;
    cyc(6);
    chk(takeover_grant_n, 8'h1);
    boot_byte_done = 1;
    cyc();
    boot_byte_done = 0;
    chk(takeover_grant_n, 8'h0);
    want = 0;
    wait_sig(1'b0, 1'b1, n);
    boot_active = 0;
    core_rst_n = 1;
  endtask
  initial begin
    cyc(6);
    rst_n = 1;
    t_idle();
    t_runon();
    t_busy();
    t_nowait();
    t_boot();
    summarize();
  end
endmodule
